/* File: mdc_arbiter.sv */
// Fixed-priority channel picker with a raised group.
// Assumes requests are already gated by enables and masks.
`timescale 1ns/100ps
module mdc_arbiter #(
  parameter int N = 32
) (
  // Requests
  input  wire logic [N-1:0]         req_in,
  input  wire logic [N-1:0]         high_in,
  // Winner
  output logic                      valid_out,
  output logic [$clog2(N)-1:0]      idx_out
);
  wire [N-1:0] hi_req = req_in & high_in;
  wire [N-1:0] pool   = (|hi_req) ? hi_req : req_in;

  always_comb
  begin
    valid_out = |req_in;
    idx_out   = '0;
    // Descending scan, so the lowest number is written last and wins
    for (int i = N - 1; i >= 0; i--)
      if (pool[i])
        idx_out = ($clog2(N))'(i);
  end
endmodule // mdc_arbiter

/* File: mdc_dma.sv */
// Multichannel DMA controller: register port, flag unit, arbiter and
// a single-beat system bus master moving elements through a FIFO.
// Assumes the requesting peripherals and the bus run on clock_in.
`timescale 1ns/100ps
module mdc_dma #(
  parameter int FIFO_DEPTH = mdc_pkg::FIFO_DEPTH_DEF
) (
  // Clock and reset
  input  wire logic                    clock_in,
  input  wire logic                    resetn_in,
  // Register port
  input  wire logic                    psel_in,
  input  wire logic                    psel_flag_in,
  input  wire logic                    penable_in,
  input  wire logic                    pwrite_in,
  input  wire logic [11:0]             paddr_in,
  input  wire logic [31:0]             pwdata_in,
  output logic      [31:0]             prdata_out,
  output logic                         pready_out,
  output logic                         pslverr_out,
  // Peripheral requests
  input  wire logic [mdc_pkg::NCH-1:0] req_burst_in,
  input  wire logic [mdc_pkg::NCH-1:0] req_single_in,
  output logic      [mdc_pkg::NCH-1:0] done_out,
  // System bus master
  output logic      [31:0]             haddr_out,
  output logic      [1:0]              htrans_out,
  output logic                         hwrite_out,
  output logic      [2:0]              hsize_out,
  output logic      [31:0]             hwdata_out,
  input  wire logic [31:0]             hrdata_in,
  input  wire logic                    hready_in,
  input  wire logic                    hresp_in,
  // Interrupts
  output logic                         irq_done_out,
  output logic                         irq_err_out
);
  import mdc_pkg::*;

  typedef enum logic [2:0] {
    ST_IDLE, ST_FETCH, ST_READ, ST_WRITE, ST_WBACK
  } mdc_state_t;

  // ------------------------------------------------------------
  // State
  // ------------------------------------------------------------
  logic            run_q;
  logic [21:0]     pri_base_q;
  logic [NCH-1:0]  burst_q, mask_q, on_q, alt_q, rank_q, swp_q;
  logic [NCH-1:0]  done_q, errf_q, done_pulse_q;
  logic            fault_q;
  logic [31:0]     prdata_q;
  mdc_state_t      state_q;
  logic [4:0]      ch_q;
  logic [1:0]      word_q;
  logic [31:0]     src_q, dst_q, ctrl_q, hwdata_q;
  logic [10:0]     rd_left_q, wr_left_q;
  logic            dph_q;
  logic [1:0]      lane_q;

  mdc_fifo_if #(.W(DATA_W)) fq ();

  // ------------------------------------------------------------
  // Register port decode
  // ------------------------------------------------------------
  wire         wr_dma = psel_in & penable_in & pwrite_in;
  wire         setup  = (psel_in | psel_flag_in) & ~penable_in;
  wire [31:0]  wd     = pwdata_in;
  wire [31:0]  alt_base;
  logic [31:0] rd_val;
  logic        dma_hit;
  logic        flag_hit;

  function automatic logic [NCH-1:0] strobe(input logic [11:0] ofs);
    strobe = (wr_dma && paddr_in == ofs) ? wd : '0;
  endfunction

  wire [NCH-1:0] w_trig      = strobe(OFS_SOFT_TRIG);
  wire [NCH-1:0] w_burst_set = strobe(OFS_BURST_SET);
  wire [NCH-1:0] w_burst_clr = strobe(OFS_BURST_CLR);
  wire [NCH-1:0] w_block_set = strobe(OFS_BLOCK_SET);
  wire [NCH-1:0] w_block_clr = strobe(OFS_BLOCK_CLR);
  wire [NCH-1:0] w_on_set    = strobe(OFS_ON_SET);
  wire [NCH-1:0] w_on_clr    = strobe(OFS_ON_CLR);
  wire [NCH-1:0] w_sel_set   = strobe(OFS_SEL_SET);
  wire [NCH-1:0] w_sel_clr   = strobe(OFS_SEL_CLR);
  wire [NCH-1:0] w_rank_set  = strobe(OFS_RANK_SET);
  wire [NCH-1:0] w_rank_clr  = strobe(OFS_RANK_CLR);
  wire [NCH-1:0] w_fault_clr = strobe(OFS_FAULT_CLR);
  wire           w_cfg       = wr_dma && paddr_in == OFS_CONFIG;
  wire           w_base      = wr_dma && paddr_in == OFS_PRI_BASE;

  assign alt_base = {pri_base_q, 10'h000} + ALT_OFFSET;

  always_comb
  begin
    rd_val  = '0;
    dma_hit = 1'b1;
    case (paddr_in)
      OFS_STATE:     rd_val = STATE_FIXED | {31'h0, run_q};
      OFS_PRI_BASE:  rd_val = {pri_base_q, 10'h000};
      OFS_ALT_BASE:  rd_val = alt_base;
      OFS_BURST_SET: rd_val = burst_q;
      OFS_BLOCK_SET: rd_val = mask_q;
      OFS_ON_SET:    rd_val = on_q;
      OFS_SEL_SET:   rd_val = alt_q;
      OFS_RANK_SET:  rd_val = rank_q;
      OFS_FAULT_CLR: rd_val = {31'h0, fault_q};
      OFS_CONFIG, OFS_SOFT_TRIG, OFS_BURST_CLR, OFS_BLOCK_CLR, OFS_ON_CLR,
      OFS_SEL_CLR, OFS_RANK_CLR: rd_val = '0;
      default:       dma_hit = 1'b0;
    endcase
    flag_hit = 1'b1;
    if (psel_flag_in)
    begin
      // Flag unit: A completion, B bus error, C unit summary
      case (paddr_in)
        OFS_FLAG_A: rd_val = done_q;
        OFS_FLAG_B: rd_val = errf_q;
        OFS_FLAG_C: rd_val = {30'h0, |errf_q, |done_q};
        default:
        begin
          rd_val   = '0;
          flag_hit = 1'b0;
        end
      endcase
    end
  end

  assign pready_out  = 1'b1;
  assign pslverr_out = penable_in & ((psel_in & ~dma_hit) | (psel_flag_in & ~flag_hit));
  assign prdata_out  = prdata_q;

  // ------------------------------------------------------------
  // Arbitration
  // ------------------------------------------------------------
  wire [NCH-1:0] hw_req = (req_burst_in | (req_single_in & ~burst_q)) & ~mask_q;
  wire [NCH-1:0] elig   = (swp_q | hw_req) & on_q & {NCH{run_q}};
  logic          g_valid;
  logic [4:0]    g_idx;

  mdc_arbiter #(.N(NCH)) u_arb (
    .req_in    (elig),
    .high_in   (rank_q),
    .valid_out (g_valid),
    .idx_out   (g_idx)
  );

  // ------------------------------------------------------------
  // Bus master access control
  // ------------------------------------------------------------
  wire mdc_mode_t mode     = mdc_mode_t'(ctrl_q[CF_CYCLE_LSB +: 3]);
  wire [1:0]      ssize    = ctrl_q[CF_SSIZE_LSB +: 2];
  wire [1:0]      dsize    = ctrl_q[CF_DSIZE_LSB +: 2];
  wire [1:0]      sinc     = ctrl_q[CF_SINC_LSB +: 2];
  wire [1:0]      dinc     = ctrl_q[CF_DINC_LSB +: 2];
  wire [31:0]     desc_adr = (alt_q[ch_q] ? alt_base : {pri_base_q, 10'h000})
                             + {23'h0, ch_q, 4'h0};
  logic           bus_req;
  logic           bus_wr;
  logic [31:0]    bus_addr;
  logic [1:0]     bus_size;

  always_comb
  begin
    bus_req  = 1'b0;
    bus_wr   = 1'b0;
    bus_addr = '0;
    bus_size = HSIZE_WORD[1:0];
    case (state_q)
      ST_FETCH:
      begin
        bus_req  = 1'b1;
        bus_addr = desc_adr + {28'h0, word_q, 2'h0};
      end
      ST_READ:
      begin
        // No read is issued unless the FIFO can take its data
        bus_req  = (rd_left_q != '0) & fq.in_ready;
        bus_addr = src_q;
        bus_size = ssize;
      end
      ST_WRITE:
      begin
        bus_req  = fq.out_valid;
        bus_wr   = 1'b1;
        bus_addr = dst_q;
        bus_size = dsize;
      end
      ST_WBACK:
      begin
        bus_req  = 1'b1;
        bus_wr   = 1'b1;
        bus_addr = desc_adr + {28'h0, DW_CTRL, 2'h0};
      end
      default: bus_req = 1'b0;
    endcase
  end

  wire addr_go  = bus_req & ~dph_q & hready_in;
  wire dat_done = dph_q & hready_in;
  wire bus_err  = dat_done & hresp_in;
  wire dat_ok   = dat_done & ~hresp_in;

  assign htrans_out = (bus_req & ~dph_q) ? HTRANS_NONSEQ : HTRANS_IDLE;
  assign haddr_out  = bus_addr;
  assign hwrite_out = bus_wr;
  assign hsize_out  = {1'b0, bus_size};
  assign hwdata_out = hwdata_q;

  // ------------------------------------------------------------
  // Element lanes and address steps
  // ------------------------------------------------------------
  wire [31:0] rd_shift = hrdata_in >> {lane_q, 3'h0};
  wire [31:0] rd_elem  = (ssize == 2'h0) ? {24'h0, rd_shift[7:0]} :
                         (ssize == 2'h1) ? {16'h0, rd_shift[15:0]} : rd_shift;
  wire [31:0] wr_elem  = (dsize == 2'h0) ? {4{fq.out_data[7:0]}} :
                         (dsize == 2'h1) ? {2{fq.out_data[15:0]}} : fq.out_data;
  wire [31:0] s_step   = (sinc == INC_FIXED) ? 32'h0 : (32'h1 << ssize);
  wire [31:0] d_step   = (dinc == INC_FIXED) ? 32'h0 : (32'h1 << dsize);

  assign fq.flush     = bus_err;
  assign fq.in_valid  = (state_q == ST_READ) & dat_ok;
  assign fq.in_data   = rd_elem;
  assign fq.out_ready = (state_q == ST_WRITE) & addr_go;

  // ------------------------------------------------------------
  // Channel events from the engine
  // ------------------------------------------------------------
  wire [NCH-1:0] ch_oh   = NCH'(1) << ch_q;
  wire           fetch_c = (state_q == ST_FETCH) & dat_ok & (word_q == DW_CTRL);
  wire           is_stop = fetch_c & (hrdata_in[CF_CYCLE_LSB +: 3] == 3'(MODE_STOP));
  wire           fin     = (state_q == ST_WBACK) & dat_ok;
  wire           m_end   = (mode == MODE_BASIC) | (mode == MODE_AUTO);
  wire           m_ret   = (mode == MODE_MSG_PRI) | (mode == MODE_MSG_ALT)
                           | (mode == MODE_PSG_PRI);
  wire           f_done  = is_stop | (fin & (m_end | mode == MODE_PINGPONG));
  wire [NCH-1:0] ev_done   = ch_oh & {NCH{f_done}};
  wire [NCH-1:0] ev_stop   = ch_oh & {NCH{is_stop | bus_err | (fin & m_end)}};
  wire [NCH-1:0] ev_toggle = ch_oh & {NCH{fin & (mode >= MODE_PINGPONG)}};
  wire [NCH-1:0] ev_repend = ch_oh & {NCH{fin & m_ret}};
  wire [NCH-1:0] ev_burst  = ch_oh & {NCH{fin & (mode == MODE_PSG_ALT)
                                          & ctrl_q[CF_NEXT_BURST]}};
  wire [NCH-1:0] ev_err    = ch_oh & {NCH{bus_err}};
  wire [NCH-1:0] grant_oh  = NCH'(1) << g_idx;
  wire           take      = (state_q == ST_IDLE) & g_valid;
  wire [NCH-1:0] taken     = grant_oh & {NCH{take}};

  // ------------------------------------------------------------
  // Register updates; hardware set wins over software clear
  // ------------------------------------------------------------
  always_ff @(posedge clock_in or negedge resetn_in)
  begin
    if (!resetn_in)
    begin
      run_q      <= 1'b0;
      pri_base_q <= PRI_BASE_RST;
      prdata_q   <= '0;
      fault_q    <= 1'b0;
    end
    else
    begin
      if (w_cfg)
        run_q <= wd[0];
      if (w_base)
        pri_base_q <= wd[31:BASE_LSB];
      if (setup)
        prdata_q <= rd_val;
      fault_q <= (fault_q & ~w_fault_clr[0]) | bus_err;
    end
  end

  always_ff @(posedge clock_in or negedge resetn_in)
  begin
    if (!resetn_in)
    begin
      burst_q      <= '0;
      mask_q       <= '0;
      on_q         <= '0;
      alt_q        <= '0;
      rank_q       <= '0;
      swp_q        <= '0;
      done_q       <= '0;
      errf_q       <= '0;
      done_pulse_q <= '0;
    end
    else
    begin
      burst_q      <= (burst_q & ~w_burst_clr) | w_burst_set | ev_burst;
      mask_q       <= (mask_q | w_block_set) & ~w_block_clr;
      on_q         <= (on_q & ~ev_stop & ~w_on_clr) | w_on_set;
      alt_q        <= ((alt_q & ~w_sel_clr) | w_sel_set) ^ ev_toggle;
      rank_q       <= (rank_q | w_rank_set) & ~w_rank_clr;
      swp_q        <= (swp_q & ~taken) | w_trig | ev_repend;
      done_q       <= (done_q & ~w_on_set) | ev_done;
      errf_q       <= (errf_q & ~{NCH{w_fault_clr[0]}}) | ev_err;
      done_pulse_q <= ev_done;
    end
  end

  assign done_out     = done_pulse_q;
  assign irq_done_out = |done_q;
  assign irq_err_out  = fault_q;

  // ------------------------------------------------------------
  // Transfer engine
  // ------------------------------------------------------------
  always_ff @(posedge clock_in or negedge resetn_in)
  begin
    if (!resetn_in)
    begin
      dph_q    <= 1'b0;
      lane_q   <= '0;
      hwdata_q <= '0;
    end
    else
    begin
      if (addr_go)
        dph_q <= 1'b1;
      else if (dat_done)
        dph_q <= 1'b0;
      if (addr_go)
        lane_q <= bus_addr[1:0];
      if (addr_go && state_q == ST_WRITE)
        hwdata_q <= wr_elem;
      else if (addr_go && state_q == ST_WBACK)
        hwdata_q <= {ctrl_q[31:3], 3'(MODE_STOP)};
    end
  end

  always_ff @(posedge clock_in or negedge resetn_in)
  begin
    if (!resetn_in)
    begin
      state_q   <= ST_IDLE;
      ch_q      <= '0;
      word_q    <= '0;
      src_q     <= '0;
      dst_q     <= '0;
      ctrl_q    <= '0;
      rd_left_q <= '0;
      wr_left_q <= '0;
    end
    else if (bus_err)
      state_q <= ST_IDLE;
    else
    begin
      case (state_q)
        ST_IDLE:
          if (g_valid)
          begin
            ch_q    <= g_idx;
            word_q  <= DW_SRC;
            state_q <= ST_FETCH;
          end
        ST_FETCH:
          if (dat_ok)
          begin
            word_q <= word_q + 2'h1;
            if (word_q == DW_SRC)
              src_q <= hrdata_in;
            if (word_q == DW_DST)
              dst_q <= hrdata_in;
            if (word_q == DW_CTRL)
            begin
              ctrl_q    <= hrdata_in;
              rd_left_q <= {1'b0, hrdata_in[CF_COUNT_LSB +: 10]} + 11'h001;
              wr_left_q <= {1'b0, hrdata_in[CF_COUNT_LSB +: 10]} + 11'h001;
              state_q   <= is_stop ? ST_IDLE : ST_READ;
            end
          end
        ST_READ:
        begin
          if (addr_go)
          begin
            src_q     <= src_q + s_step;
            rd_left_q <= rd_left_q - 11'h001;
          end
          if (!dph_q && !addr_go && (rd_left_q == '0 || !fq.in_ready))
            state_q <= ST_WRITE;
        end
        ST_WRITE:
        begin
          if (addr_go)
          begin
            dst_q     <= dst_q + d_step;
            wr_left_q <= wr_left_q - 11'h001;
          end
          if (!dph_q && !fq.out_valid)
            state_q <= (wr_left_q == '0) ? ST_WBACK : ST_READ;
        end
        ST_WBACK:
          if (dat_ok)
            state_q <= ST_IDLE;
        default: state_q <= ST_IDLE;
      endcase
    end
  end

  mdc_fifo #(.W(DATA_W), .DEPTH(FIFO_DEPTH)) u_fifo (
    .clock_in  (clock_in),
    .resetn_in (resetn_in),
    .f         (fq)
  );
endmodule // mdc_dma

/* File: mdc_dma_chk.sv */
// Port-level properties of the DMA controller.
// Assumes the single clock_in domain and active-low resetn_in.
`timescale 1ns/100ps
module mdc_dma_chk (
  input wire logic        clock_in, resetn_in, psel_in, psel_flag_in, penable_in, pwrite_in,
  input wire logic [11:0] paddr_in,
  input wire logic [31:0] prdata_out, done_out,
  input wire logic        pslverr_out, hready_in, hresp_in, irq_err_out,
  input wire logic [1:0]  htrans_out,
  input wire logic [2:0]  hsize_out
);
  import mdc_pkg::*;
  default clocking @(posedge clock_in); endclocking
  default disable iff (!resetn_in);
  wire rd_setup = psel_in && !penable_in && !pwrite_in;
  property p_state; rd_setup && paddr_in == OFS_STATE |=> (prdata_out & 32'hFFFF_FF0E) == STATE_FIXED; endproperty
  a_state: assert property (p_state) else $error("state fixed bits wrong");
  property p_base; rd_setup && paddr_in == OFS_PRI_BASE |=> prdata_out[9:0] == 10'h000; endproperty
  a_base: assert property (p_base) else $error("base low bits not zero");
  property p_err; pslverr_out |-> (psel_in || psel_flag_in) && penable_in; endproperty
  a_err: assert property (p_err) else $error("error outside access phase");
  property p_trans; htrans_out == HTRANS_IDLE || htrans_out == HTRANS_NONSEQ; endproperty
  a_trans: assert property (p_trans) else $error("bad transfer kind");
  property p_one; htrans_out == HTRANS_NONSEQ && hready_in |=> htrans_out == HTRANS_IDLE; endproperty
  a_one: assert property (p_one) else $error("second address while one outstanding");
  property p_size; htrans_out == HTRANS_NONSEQ |-> hsize_out <= HSIZE_WORD; endproperty
  a_size: assert property (p_size) else $error("element size out of range");
  property p_done; done_out != 32'h0 |=> done_out == 32'h0; endproperty
  a_done: assert property (p_done) else $error("completion pulse too long");
  property p_fault; $rose(irq_err_out) |-> $past(hresp_in) && $past(hready_in); endproperty
  a_fault: assert property (p_fault) else $error("error interrupt without bus error");
  c_state: cover property (rd_setup && paddr_in == OFS_STATE);
  c_done: cover property (done_out != 32'h0);
  c_fault: cover property ($rose(irq_err_out));
endmodule // mdc_dma_chk
bind mdc_dma mdc_dma_chk mdc_dma_chk_i (.*);

/* File: mdc_dma_tb.sv */
// Self-checking bench: register port, two copies, arbitration and a bus error.
// Assumes mdc_mem as bus partner, preloaded through its mem array.
`timescale 1ns/100ps
module mdc_dma_tb;
  import mdc_pkg::*;
  typedef struct {string n; logic [32:0] e; logic [31:0] m;} mdc_exp_t;
  logic clock_in = 0, resetn_in = 0, psel_in = 0, psel_flag_in = 0, penable_in = 0;
  logic pwrite_in = 0, slow = 0, hwrite_out, hready_in, hresp_in;
  logic pready_out, pslverr_out, irq_done_out, irq_err_out;
  logic [11:0] paddr_in = 12'h000;
  logic [31:0] pwdata_in = 32'h0, prdata_out, haddr_out, hwdata_out, hrdata_in, done_out;
  logic [31:0] req_burst_in = 32'h0, req_single_in = 32'h0;
  logic [1:0]  htrans_out;
  logic [2:0]  hsize_out;
  mdc_exp_t rq[$];
  mdc_exp_t dq[$];
  mdc_exp_t x;
  int fails = 0, num_checks = 0;
  always #4 clock_in = !clock_in;
  mdc_dma #(.FIFO_DEPTH(4)) mdc_dma_i (.*);
  mdc_mem mdc_mem_i (.clock_in(clock_in), .resetn_in(resetn_in), .haddr_in(haddr_out),
    .htrans_in(htrans_out), .hwrite_in(hwrite_out), .hwdata_in(hwdata_out), .slow_in(slow),
    .hrdata_out(hrdata_in), .hready_out(hready_in), .hresp_out(hresp_in));
  task automatic cmp(input string n, input logic [32:0] e, g, input logic [31:0] m);
    num_checks++;
    if ((g & {1'b1, m}) !== (e & {1'b1, m}))
    begin
      fails++;
      $display("[ERR] %s expected %h seen %h", n, e, g);
    end
  endtask
  // Watcher: takes the oldest note whenever a read or a completion shows
  always @(posedge clock_in)
  begin
    if ((psel_in || psel_flag_in) && penable_in && !pwrite_in)
    begin
      x = rq.size() ? rq.pop_front() : mdc_exp_t'{"read", 'x, '1};
      cmp(x.n, x.e, {pslverr_out | !pready_out, prdata_out}, x.m);
    end
    if (done_out !== 32'h0)
    begin
      x = dq.size() ? dq.pop_front() : mdc_exp_t'{"done", 33'h0, '1};
      cmp(x.n, x.e, {1'b0, done_out}, x.m);
    end
  end
  task automatic bus(input logic f, w, input logic [11:0] a, input logic [31:0] d);
    @(posedge clock_in);
    #1 {psel_flag_in, psel_in, pwrite_in, paddr_in, pwdata_in} = {f, !f, w, a, d};
    @(posedge clock_in);
    #1 penable_in = 1;
    @(posedge clock_in);
    #1 {psel_flag_in, psel_in, penable_in} = 3'h0;
  endtask
  task automatic rd(input logic f, input logic [11:0] a, input logic [32:0] e, input logic [31:0] m);
    rq.push_back(mdc_exp_t'{$sformatf("reg %0d/%h", f, a), e, m});
    bus(f, 0, a, 32'h0);
  endtask
  task automatic desc(input int c, input logic [31:0] s, d, k);
    {mdc_mem_i.mem[c * 4], mdc_mem_i.mem[c * 4 + 1], mdc_mem_i.mem[c * 4 + 2]} = {s, d, k};
  endtask
  function automatic logic [31:0] ctl(input int n, input logic [1:0] di);
    return {di, 2'h2, 2'h2, 2'h2, 10'h000, 10'(n - 1), 4'h1};
  endfunction
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  initial
  begin
    #100000 fails++;
    give_verdict();
  end
  initial
  begin
    void'($urandom(65));
    for (int i = 0; i < 8; i++) mdc_mem_i.mem[12'h400 + i] = $urandom;
    mdc_mem_i.mem[12'h441] = $urandom;
    repeat (5) @(posedge clock_in);
    #1 resetn_in = 1;
    rd(0, OFS_STATE, {1'b0, STATE_FIXED}, 32'hFFFF_FF0F);
    rd(0, OFS_ALT_BASE, {1'b0, ALT_OFFSET}, '1);
    rd(0, 12'h040, 33'h1_0000_0000, '1);
    bus(0, 1, OFS_PRI_BASE, '1);
    rd(0, OFS_PRI_BASE, 33'h0_FFFF_FC00, '1);
    rd(0, OFS_ALT_BASE, 33'h0_FFFF_FE00, '1);
    bus(0, 1, OFS_PRI_BASE, 32'h0);
    bus(0, 1, OFS_CONFIG, 32'h1);
    rd(0, OFS_STATE, {1'b0, STATE_FIXED | 32'h1}, 32'hFFFF_FF0F);
    bus(0, 1, OFS_BLOCK_SET, '1);
    bus(0, 1, OFS_ON_SET, '1);
    bus(0, 1, OFS_BLOCK_CLR, 32'h5);
    rd(0, OFS_BLOCK_SET, 33'h0_FFFF_FFFA, '1);
    bus(0, 1, OFS_RANK_SET, 32'h4);
    $display("test registers done");
    desc(2, 32'h1000, 32'h2000, ctl(6, 2'h2));
    desc(0, 32'h1100, 32'h2100, ctl(2, INC_FIXED) ^ 32'h2);
    desc(1, 32'h8000_0000, 32'h2200, ctl(1, 2'h2));
    slow = 1;
    req_burst_in = 32'h2;
    dq.push_back(mdc_exp_t'{"done high", 33'h4, '1});
    dq.push_back(mdc_exp_t'{"done normal", 33'h1, '1});
    bus(0, 1, OFS_SOFT_TRIG, 32'h5);
    for (int i = 0; i < 3000 && dq.size(); i++) @(posedge clock_in);
    while (dq.size()) cmp("missing done", dq.pop_front().e, 'x, '1);
    for (int i = 0; i < 6; i++) cmp("copy", mdc_mem_i.mem[12'h400 + i], mdc_mem_i.mem[12'h800 + i], '1);
    cmp("fixed dst", mdc_mem_i.mem[12'h441], mdc_mem_i.mem[12'h840], '1);
    cmp("write back", ctl(6, 2'h2) & ~32'h7, mdc_mem_i.mem[10], '1);
    cmp("irq done", 33'h1, irq_done_out, '1);
    rd(0, OFS_SEL_SET, 33'h1, '1);
    rd(0, OFS_FAULT_CLR, 33'h0, 32'h1);
    $display("test transfers done");
    slow = 0;
    bus(0, 1, OFS_BLOCK_CLR, 32'h2);
    for (int i = 0; i < 500 && !irq_err_out; i++) @(posedge clock_in);
    cmp("irq err", 33'h1, irq_err_out, '1);
    #1 req_burst_in = 32'h0;
    rd(0, OFS_FAULT_CLR, 33'h1, 32'h1);
    rd(1, OFS_FLAG_A, 33'h5, '1);
    rd(1, OFS_FLAG_B, 33'h2, '1);
    rd(1, OFS_FLAG_C, 33'h3, '1);
    bus(0, 1, OFS_FAULT_CLR, 32'h1);
    rd(1, OFS_FLAG_B, 33'h0, '1);
    rd(0, OFS_FAULT_CLR, 33'h0, 32'h1);
    $display("test fault done");
    give_verdict();
  end
endmodule // mdc_dma_tb

/* File: mdc_fifo.sv */
// Staging FIFO for read elements awaiting their write.
// Assumes DEPTH is a power of two.
`timescale 1ns/100ps
module mdc_fifo #(
  parameter int W     = 32,
  parameter int DEPTH = 32
) (
  // Clock and reset
  input wire logic    clock_in,
  input wire logic    resetn_in,
  // Stream
  mdc_fifo_if.store   f
);
  localparam int AW = $clog2(DEPTH);

  logic [W-1:0] mem_q [DEPTH];
  logic [AW-1:0] wp_q;
  logic [AW-1:0] rp_q;
  logic [AW:0]   cnt_q;
  wire           push = f.in_valid & f.in_ready;
  wire           pop  = f.out_valid & f.out_ready;

  assign f.in_ready  = (cnt_q != (AW+1)'(DEPTH));
  assign f.out_valid = (cnt_q != '0);
  assign f.out_data  = mem_q[rp_q];

  always_ff @(posedge clock_in)
  begin
    if (push)
      mem_q[wp_q] <= f.in_data;
  end

  always_ff @(posedge clock_in or negedge resetn_in)
  begin
    if (!resetn_in)
    begin
      wp_q  <= '0;
      rp_q  <= '0;
      cnt_q <= '0;
    end
    else if (f.flush)
    begin
      wp_q  <= '0;
      rp_q  <= '0;
      cnt_q <= '0;
    end
    else
    begin
      wp_q  <= wp_q + AW'(push);
      rp_q  <= rp_q + AW'(pop);
      cnt_q <= cnt_q + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule // mdc_fifo

/* File: mdc_fifo_if.sv */
// Element stream between the transfer engine and its staging FIFO.
// Assumes both ends run on the same clock.
`timescale 1ns/100ps
interface mdc_fifo_if #(parameter int W = 32);
  logic         flush;
  logic         in_valid;
  logic         in_ready;
  logic [W-1:0] in_data;
  logic         out_valid;
  logic         out_ready;
  logic [W-1:0] out_data;
  modport prod  (output flush, in_valid, in_data, out_ready,
                 input  in_ready, out_valid, out_data);
  modport store (input  flush, in_valid, in_data, out_ready,
                 output in_ready, out_valid, out_data);
endinterface

/* File: mdc_mem.sv */
// Word memory on the system bus, answering promptly or after two waits.
// Assumes single NONSEQ beats; any address with bit 31 set is answered with an error.
`timescale 1ns/100ps
module mdc_mem (
  // Clock and reset
  input  wire logic        clock_in,
  input  wire logic        resetn_in,
  // Bus from the controller
  input  wire logic [31:0] haddr_in,
  input  wire logic [1:0]  htrans_in,
  input  wire logic        hwrite_in,
  input  wire logic [31:0] hwdata_in,
  input  wire logic        slow_in,
  // Answer
  output logic      [31:0] hrdata_out,
  output logic             hready_out,
  output logic             hresp_out
);
  logic [31:0] mem [0:4095];
  logic [31:0] a_q;
  logic        ph_q;
  logic        w_q;
  logic [1:0]  wt_q;
  assign hready_out = !ph_q || wt_q == 2'h0;
  assign hresp_out  = ph_q && a_q[31];
  // Outside a read data phase the lines carry the inverse, never a stale match
  assign hrdata_out = (ph_q && !w_q && hready_out) ? mem[a_q[13:2]] : ~mem[a_q[13:2]];
  always @(posedge clock_in or negedge resetn_in)
    if (!resetn_in)
    begin
      ph_q <= 1'b0;
      a_q  <= 32'h0;
    end
    else if (hready_out)
    begin
      if (ph_q && w_q && !a_q[31])
        mem[a_q[13:2]] <= hwdata_in;
      ph_q <= htrans_in == 2'h2;
      a_q  <= haddr_in;
      w_q  <= hwrite_in;
      wt_q <= slow_in ? 2'h2 : 2'h0;
    end
    else
      wt_q <= wt_q - 2'h1;
endmodule // mdc_mem

/* File: mdc_pkg.sv */
// Shared constants for the multichannel DMA controller.
// Assumes a 32-bit peripheral register port and a 32-bit system bus.
package mdc_pkg;

  // ------------------------------------------------------------
  // Sizes
  // ------------------------------------------------------------
  localparam int NCH            = 32;
  localparam int FIFO_DEPTH_DEF = 32;
  localparam int DATA_W         = 32;

  // ------------------------------------------------------------
  // Controller register offsets
  // ------------------------------------------------------------
  localparam logic [11:0] OFS_STATE     = 12'h000;
  localparam logic [11:0] OFS_CONFIG    = 12'h004;
  localparam logic [11:0] OFS_PRI_BASE  = 12'h008;
  localparam logic [11:0] OFS_ALT_BASE  = 12'h00C;
  localparam logic [11:0] OFS_SOFT_TRIG = 12'h014;
  localparam logic [11:0] OFS_BURST_SET = 12'h018;
  localparam logic [11:0] OFS_BURST_CLR = 12'h01C;
  localparam logic [11:0] OFS_BLOCK_SET = 12'h020;
  localparam logic [11:0] OFS_BLOCK_CLR = 12'h024;
  localparam logic [11:0] OFS_ON_SET    = 12'h028;
  localparam logic [11:0] OFS_ON_CLR    = 12'h02C;
  localparam logic [11:0] OFS_SEL_SET   = 12'h030;
  localparam logic [11:0] OFS_SEL_CLR   = 12'h034;
  localparam logic [11:0] OFS_RANK_SET  = 12'h038;
  localparam logic [11:0] OFS_RANK_CLR  = 12'h03C;
  localparam logic [11:0] OFS_FAULT_CLR = 12'h04C;

  // ------------------------------------------------------------
  // Flag unit register offsets
  // ------------------------------------------------------------
  localparam logic [11:0] OFS_FLAG_A = 12'h000;
  localparam logic [11:0] OFS_FLAG_B = 12'h004;
  localparam logic [11:0] OFS_FLAG_C = 12'h008;

  // ------------------------------------------------------------
  // Fixed values and reset values
  // ------------------------------------------------------------
  localparam logic [31:0] STATE_FIXED  = 32'h101F_0000;
  localparam logic [21:0] PRI_BASE_RST = 22'h00_0000;
  localparam int          BASE_LSB     = 10;
  localparam logic [31:0] ALT_OFFSET   = 32'h0000_0200;

  // ------------------------------------------------------------
  // Descriptor layout: 16 bytes per channel
  // ------------------------------------------------------------
  localparam logic [1:0] DW_SRC  = 2'h0;
  localparam logic [1:0] DW_DST  = 2'h1;
  localparam logic [1:0] DW_CTRL = 2'h2;
  localparam int CF_CYCLE_LSB = 0;
  localparam int CF_NEXT_BURST = 3;
  localparam int CF_COUNT_LSB = 4;
  localparam int CF_SSIZE_LSB = 24;
  localparam int CF_SINC_LSB  = 26;
  localparam int CF_DSIZE_LSB = 28;
  localparam int CF_DINC_LSB  = 30;
  localparam logic [1:0] INC_FIXED = 2'h3;

  // ------------------------------------------------------------
  // System bus encodings
  // ------------------------------------------------------------
  localparam logic [1:0] HTRANS_IDLE   = 2'h0;
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
  localparam logic [2:0] HSIZE_WORD    = 3'h2;

  typedef enum logic [2:0] {
    MODE_STOP, MODE_BASIC, MODE_AUTO, MODE_PINGPONG,
    MODE_MSG_PRI, MODE_MSG_ALT, MODE_PSG_PRI, MODE_PSG_ALT
  } mdc_mode_t;

endpackage
